// [core/dtd_dialer.sv]
/*
 * Tone dialer: register file on Avalon-MM, tone sequencer, row and column
 * dividers, transmit mute, hook output and completion flag.
 * Assumes a 100 MHz clock and the fast oscillator on a pin; the pulse
 * generator sits elsewhere and shares the mode bit.
 */
// Our own choices: the Avalon-MM slave port and the register offsets.
// Functional notes
// - Completion sets done flag bit zero.
// - Mask gates request; flag sets regardless.
// - Writing one clears flag; zero keeps.
// - Tone mode after reset; bit three selects.
// - Two integer dividers from fast oscillator.
// - Divider ratios give the listed frequencies.
// - Enable bits pick DC, column, row, dual.
// - Both enable bits reset to one.
// - Codes one to nine follow keypad.
// - Other codes map to fixed pairs.
// - Code write starts tone; dual sums.
// - Transmit mute falls as tone starts.
// - Minimum tone 94 or 47 msec.
// - Continuous bit holds tone until cleared.
// - Tone ends low, then 94 msec pause.
// - Flag sets after pause elapses.
// - Mute held 4 msec, no gap retrigger.
// - Off-hook bit drives dial pulse pin.
// - Control write stores mode, ratio, rate.
// - Without option duration bit reads zero.
`timescale 1ns/1ns
`default_nettype none
`include "dtd_consts.svh"
module dtd_dialer #(
  parameter bit [31:0] TONE_LONG_CYC  = `DTD_TONE_LONG_US * `DTD_CLK_MHZ,
  parameter bit [31:0] TONE_SHORT_CYC = `DTD_TONE_SHORT_US * `DTD_CLK_MHZ,
  parameter bit [31:0] PAUSE_CYC      = `DTD_PAUSE_US * `DTD_CLK_MHZ,
  parameter bit [31:0] MUTE_HOLD_CYC  = `DTD_MUTE_HOLD_US * `DTD_CLK_MHZ,
  parameter bit        DUR_OPT_FITTED = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Fast oscillator pin
  input  wire logic        fast_oscillator,
  // Line side
  output logic [1:0]       tone_out,
  output logic             tx_mute_n,
  output logic             dial_pulse_out_n,
  // CPU interrupt request
  output logic             dial_irq
);
  import dtd_pkg::*;

  // Register state.
  logic [3:0]    ctrl_reg;
  logic [3:0]    tone_reg;
  logic [3:0]    code_reg;
  logic [3:0]    hook_reg;
  logic          mask_reg;
  logic          flag_reg;
  logic          ack_reg;
  logic [31:0]   rdata_reg;
  dtd_state_type state_reg;
  dtd_state_type state_next;
  logic [31:0]   cnt_reg;
  logic [31:0]   cnt_next;
  logic          cont_reg;
  logic [1:0]    tone_reg_out;
  logic          mute_reg;
  logic [1:0]    tone_next;

  // Code to row and column index, row in the high pair of bits.
  function automatic logic [3:0] dtd_map(input logic [3:0] code);
    logic [3:0] rc;
    rc = 4'h0;
    case (code)
      4'h0:    rc = 4'h3;
      4'hA:    rc = 4'hD;
      4'hB:    rc = 4'hE;
      4'hC:    rc = 4'hC;
      4'hD:    rc = 4'h7;
      4'hE:    rc = 4'hF;
      4'hF:    rc = 4'hB;
      4'h1, 4'h2, 4'h3: rc = {2'h0, 2'(code - 4'h1)};
      4'h4, 4'h5, 4'h6: rc = {2'h1, 2'(code - 4'h4)};
      default: rc = {2'h2, 2'(code - 4'h7)};
    endcase
    return rc;
  endfunction

  // Half period of a tone; col selects the column table.
  function automatic dtd_half_type dtd_half(input logic col,
                                            input logic [1:0] idx);
    dtd_half_type h;
    h = `DTD_ROW1_HALF;
    case ({col, idx})
      3'h0:    h = `DTD_ROW1_HALF;
      3'h1:    h = `DTD_ROW2_HALF;
      3'h2:    h = `DTD_ROW3_HALF;
      3'h3:    h = `DTD_ROW4_HALF;
      3'h4:    h = `DTD_COL1_HALF;
      3'h5:    h = `DTD_COL2_HALF;
      3'h6:    h = `DTD_COL3_HALF;
      default: h = `DTD_COL4_HALF;
    endcase
    return h;
  endfunction

  // Bus decode. One wait state: the access completes on the second edge.
  wire       req     = avs_read | avs_write;
  wire       wr_fire = avs_write & ack_reg & avs_byteenable[0];
  wire [3:0] wd      = avs_writedata[3:0];
  wire hit_ctrl = (avs_address == {`DTD_IDX_CTRL, 2'b00});
  wire hit_tone = (avs_address == {`DTD_IDX_TONE, 2'b00});
  wire hit_code = (avs_address == {`DTD_IDX_CODE, 2'b00});
  wire hit_hook = (avs_address == {`DTD_IDX_HOOK, 2'b00});
  wire hit_mask = (avs_address == {`DTD_IDX_MASK, 2'b00});
  wire hit_flag = (avs_address == {`DTD_IDX_FLAG, 2'b00});
  logic [3:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_reg;
    end else if (hit_tone) begin
      rd_mux = tone_reg;
    end else if (hit_code) begin
      rd_mux = code_reg;
    end else if (hit_hook) begin
      rd_mux = hook_reg;
    end else if (hit_mask) begin
      rd_mux = {3'h0, mask_reg};
    end else if (hit_flag) begin
      rd_mux = {3'h0, flag_reg};
    end else begin
      rd_mux = 4'h0;
    end
  end

  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // Register writes.
  wire tone_mode = ~ctrl_reg[`DTD_B_MODE];
  wire code_wr   = wr_fire & hit_code;
  wire can_start = (state_reg == DTD_IDLE) || (state_reg == DTD_HOLD);
  wire start     = code_wr & tone_mode & can_start;
  wire pause_end = (state_reg == DTD_PAUSE) && (cnt_reg == 32'h0);
  wire flag_clr  = wr_fire & hit_flag & wd[`DTD_B_FLAG];
  // Duration bit is absent without the option and then reads zero.
  wire [3:0] tone_wd = DUR_OPT_FITTED ? wd :
                       (wd & ~(4'h1 << `DTD_B_DUR));
  wire short_dur = DUR_OPT_FITTED & tone_reg[`DTD_B_DUR];
  wire [31:0] dur_cyc = short_dur ? TONE_SHORT_CYC : TONE_LONG_CYC;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= {28'h000_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `DTD_RST_CTRL;
      tone_reg <= `DTD_RST_TONE;
      code_reg <= 4'h0;
      hook_reg <= `DTD_RST_HOOK;
      mask_reg <= 1'b0;
    end else if (wr_fire) begin
      if (hit_ctrl) begin
        ctrl_reg <= wd & 4'hB;
      end
      if (hit_tone) begin
        tone_reg <= tone_wd;
      end
      if (hit_code) begin
        code_reg <= wd;
      end
      if (hit_hook) begin
        hook_reg <= wd & 4'hB;
      end
      if (hit_mask) begin
        mask_reg <= wd[`DTD_B_MASK];
      end
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (pause_end) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // Sequencer: tone, fixed pause, then mute hold that a new code can
  // cut short without lifting mute.
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg == 32'h0) ? 32'h0 : cnt_reg - 32'h1;
    case (state_reg)
      DTD_IDLE: begin
        if (start) begin
          state_next = DTD_TONE;
          cnt_next   = dur_cyc - 32'h1;
        end
      end
      DTD_TONE: begin
        // Continuous tone outlasts the minimum until its bit is cleared.
        if (cnt_reg == 32'h0 &&
            !(cont_reg && tone_reg[`DTD_B_CONT])) begin
          state_next = DTD_PAUSE;
          cnt_next   = PAUSE_CYC - 32'h1;
        end
      end
      DTD_PAUSE: begin
        if (cnt_reg == 32'h0) begin
          state_next = DTD_HOLD;
          cnt_next   = MUTE_HOLD_CYC - 32'h1;
        end
      end
      DTD_HOLD: begin
        if (start) begin
          state_next = DTD_TONE;
          cnt_next   = dur_cyc - 32'h1;
        end else if (cnt_reg == 32'h0) begin
          state_next = DTD_IDLE;
        end
      end
      default: begin
        state_next = DTD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DTD_IDLE;
      cnt_reg   <= 32'h0;
      cont_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (start) begin
        cont_reg <= tone_reg[`DTD_B_CONT];
      end
    end
  end

  // Dividers run from the fast oscillator only while a tone sounds.
  logic       osc_tick;
  logic       row_sq;
  logic       col_sq;
  wire [3:0]  rc     = dtd_map(code_reg);
  wire        run    = (state_reg == DTD_TONE);
  dtd_osc_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .osc_pin  (fast_oscillator),
    .osc_tick (osc_tick)
  );
  dtd_tone_div u_row (
    .clk         (clk),
    .rst_n       (rst_n),
    .osc_tick    (osc_tick),
    .run         (run),
    .half_period (dtd_half(1'b0, rc[3:2])),
    .square      (row_sq)
  );
  dtd_tone_div u_col (
    .clk         (clk),
    .rst_n       (rst_n),
    .osc_tick    (osc_tick),
    .run         (run),
    .half_period (dtd_half(1'b1, rc[1:0])),
    .square      (col_sq)
  );

  // Output level: 0 low, 1 mid-supply, 2 one tone high, dual sums.
  always_comb begin
    tone_next = 2'h0;
    if (run) begin
      case ({tone_reg[`DTD_B_ROWEN], tone_reg[`DTD_B_COLEN]})
        2'b00:   tone_next = 2'h1;
        2'b01:   tone_next = {col_sq, 1'b0};
        2'b10:   tone_next = {row_sq, 1'b0};
        default: tone_next = {1'b0, row_sq} + {1'b0, col_sq};
      endcase
    end
  end

  // Mute follows the next state so it falls on the tone's first cycle.
  wire mute_next = hook_reg[`DTD_B_TXMEN] &&
                   (state_next != DTD_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_reg_out <= 2'h0;
      mute_reg     <= 1'b0;
    end else begin
      tone_reg_out <= tone_next;
      mute_reg     <= mute_next;
    end
  end

  assign tone_out         = tone_reg_out;
  assign tx_mute_n        = ~mute_reg;
  assign dial_pulse_out_n = hook_reg[`DTD_B_HOOK];
  assign dial_irq         = flag_reg & mask_reg;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tone_end;
    (state_reg == DTD_TONE) ##1 (state_reg == DTD_PAUSE);
  endsequence
  sequence s_hold_entry;
    (state_reg == DTD_PAUSE) ##1 (state_reg == DTD_HOLD);
  endsequence

  property p_flag_set;
    pause_end |=> flag_reg && (state_reg == DTD_HOLD);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set after pause");

  property p_irq_gate;
    pause_end ##1 mask_reg |-> dial_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq not raised on an unmasked completion");

  property p_flag_clear;
    flag_clr && !pause_end |=> !flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag survived a clear");

  property p_flag_keep;
    flag_reg && !flag_clr |=> flag_reg;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag lost without a clear");

  property p_start;
    start ##1 hook_reg[`DTD_B_TXMEN] |-> (state_reg == DTD_TONE) && !tx_mute_n;
  endproperty
  a_start: assert property (p_start)
    else $error("tone or mute did not start");

  property p_pulse_ignore;
    code_wr && !tone_mode && (state_reg == DTD_IDLE) |=> state_reg == DTD_IDLE;
  endproperty
  a_pulse_ignore: assert property (p_pulse_ignore)
    else $error("tone started in pulse mode");

  property p_mute_hold;
    s_hold_entry ##0 hook_reg[`DTD_B_TXMEN] |-> !tx_mute_n [*2];
  endproperty
  a_mute_hold: assert property (p_mute_hold)
    else $error("mute lifted during hold");

  property p_tone_low;
    s_tone_end |=> tone_out == 2'h0;
  endproperty
  a_tone_low: assert property (p_tone_low)
    else $error("tone output not low after tone");

  property p_hook;
    wr_fire && hit_hook |=> dial_pulse_out_n == $past(wd[`DTD_B_HOOK]);
  endproperty
  a_hook: assert property (p_hook)
    else $error("dial pulse pin not following hook bit");
endmodule
`default_nettype wire

// [core/dtd_osc_sync.sv]
/*
 * Brings the fast oscillator pin into the system clock domain and marks
 * each of its rising edges with a one-cycle tick.
 * Assumes the system clock is well above twice the oscillator rate.
 */
`timescale 1ns/1ns
`default_nettype none
module dtd_osc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Oscillator pin and tick
  input  wire logic osc_pin,
  output logic      osc_tick
);
  import dtd_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= osc_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign osc_tick = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// [core/dtd_tone_div.sv]
/*
 * Integer divider that turns oscillator ticks into a square wave whose
 * half period is given in ticks. Assumes the half period holds steady
 * while run is high.
 */
`timescale 1ns/1ns
`default_nettype none
module dtd_tone_div (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Control
  input  wire logic                  osc_tick,
  input  wire logic                  run,
  input  wire dtd_pkg::dtd_half_type half_period,
  // Square wave
  output logic                       square
);
  import dtd_pkg::*;

  dtd_half_type cnt_reg;
  logic         sq_reg;
  wire          wrap = osc_tick && (cnt_reg == half_period - 12'h001);

  // Stopping clears the phase so every tone starts low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 12'h000;
      sq_reg  <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 12'h000;
      sq_reg  <= 1'b0;
    end else if (wrap) begin
      cnt_reg <= 12'h000;
      sq_reg  <= ~sq_reg;
    end else if (osc_tick) begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  assign square = sq_reg;
endmodule
`default_nettype wire

// [pkg/dtd_consts.svh]
/*
 * Register indices, field positions, reset values and timing figures of
 * the tone dialer. Assumes a 100 MHz system clock and 32-bit Avalon data.
 */
`ifndef DTD_CONSTS_SVH
`define DTD_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define DTD_IDX_CTRL 16'hFF10
`define DTD_IDX_TONE 16'hFF16
`define DTD_IDX_CODE 16'hFF17
`define DTD_IDX_HOOK 16'hFF18
`define DTD_IDX_MASK 16'hFFE9
`define DTD_IDX_FLAG 16'hFFF9

// Field positions.
`define DTD_B_MODE  3
`define DTD_B_RATIO 1
`define DTD_B_RATE  0
`define DTD_B_CONT  3
`define DTD_B_DUR   2
`define DTD_B_ROWEN 1
`define DTD_B_COLEN 0
`define DTD_B_TXMEN 0
`define DTD_B_RXMEN 1
`define DTD_B_HOOK  3
`define DTD_B_FLAG  0
`define DTD_B_MASK  0

// Reset values.
`define DTD_RST_CTRL 4'h0
`define DTD_RST_TONE 4'h3
`define DTD_RST_HOOK 4'h0

// Timing in microseconds and the clock rate in MHz.
`define DTD_CLK_MHZ       100
`define DTD_TONE_LONG_US  94000
`define DTD_TONE_SHORT_US 47000
`define DTD_PAUSE_US      94000
`define DTD_MUTE_HOLD_US  4000

// Half periods of each tone in fast oscillator edges.
`define DTD_ROW1_HALF 12'h9F8
`define DTD_ROW2_HALF 12'h910
`define DTD_ROW3_HALF 12'h828
`define DTD_ROW4_HALF 12'h77A
`define DTD_COL1_HALF 12'h5C0
`define DTD_COL2_HALF 12'h540
`define DTD_COL3_HALF 12'h4C0
`define DTD_COL4_HALF 12'h440

`endif

// [pkg/dtd_pkg.sv]
/*
 * Types shared by the tone dialer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package dtd_pkg;
  typedef enum logic [1:0] {
    DTD_IDLE  = 2'b00,
    DTD_TONE  = 2'b01,
    DTD_PAUSE = 2'b10,
    DTD_HOLD  = 2'b11
  } dtd_state_type;

  typedef logic [11:0] dtd_half_type;
endpackage
`default_nettype wire

// [tb/dtd_line_model.sv]
/*
 * Far-side model of the dialer: the fast oscillator module and the line
 * interface that follows the hook pin.
 * Assumes the dialer synchronises the oscillator pin itself.
 */
`timescale 1ns/1ns
`default_nettype none
module dtd_line_model (
  // Line side
  input  wire logic hook_pin_n,
  // Oscillator and line state
  output logic      osc,
  output logic      off_hook
);
  // Runs from time zero, so it has long settled before the bench dials.
  // A half period of 140 ns keeps close to the nominal oscillator rate.
  initial begin
    osc = 1'b0;
    forever begin
      #140 osc = ~osc;
    end
  end

  assign off_hook = hook_pin_n;
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for the tone dialer: Avalon-MM tasks and dialing
 * sequences. Assumes the dialer is built with short tone, pause and
 * mute-hold counts, from which the expected tone, pause and mute-hold lengths here are derived.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dtd_consts.svh"
module tb;
  import dtd_pkg::*;
  localparam int TL = 20;
  localparam int TS = 10;
  localparam int PC = 20;
  localparam int MH = 8;
  // System clock periods per oscillator period (280 ns over 10 ns).
  localparam int OSC_RATIO = 28;
  localparam logic [15:0] CT = `DTD_IDX_CTRL;
  localparam logic [15:0] TN = `DTD_IDX_TONE;
  localparam logic [15:0] CD = `DTD_IDX_CODE;
  localparam logic [15:0] HK = `DTD_IDX_HOOK;
  localparam logic [15:0] MK = `DTD_IDX_MASK;
  localparam logic [15:0] FL = `DTD_IDX_FLAG;
  logic        clk;
  logic        rst_n;
  logic [17:0] adr;
  logic        rd;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic        osc;
  logic [1:0]  tone;
  logic        mute_n;
  logic        pulse_pin_n;
  logic        irq;
  logic        hooked;
  logic        watch;
  logic        gap;
  int          errors;
  int          n_checks;
  int          k;

  dtd_dialer #(.TONE_LONG_CYC(TL), .TONE_SHORT_CYC(TS), .PAUSE_CYC(PC),
               .MUTE_HOLD_CYC(MH), .DUR_OPT_FITTED(1'b1)) u_dut (
    .clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .fast_oscillator(osc),
    .tone_out(tone), .tx_mute_n(mute_n), .dial_pulse_out_n(pulse_pin_n),
    .dial_irq(irq));

  dtd_line_model u_line (.hook_pin_n(pulse_pin_n), .osc(osc),
                         .off_hook(hooked));

  always #5 clk = ~clk;

  // Any release of the mute while a retrigger is pending is a gap.
  always @(negedge clk) begin
    if (watch && mute_n !== 1'b0) begin
      gap = 1'b1;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask

  // Counts may land a cycle or two off because of pipeline stages.
  task automatic near(string s, int e, int g);
    n_checks++;
    if (g < e - 2 || g > e + 2) begin
      errors++;
      $display("FAIL %s expected %0d seen %0d", s, e, g);
    end
  endtask

  // A wait that uses up its bound is a mismatch and ends the run.
  task automatic guard(string s, int n, int lim);
    if (n >= lim) begin
      errors++;
      $display("FAIL %s expected below %0d seen %0d", s, lim, n);
      report_and_stop();
    end
  endtask

  // The request stands until the rising edge that samples waitrequest
  // low; read data is taken at that edge and only then is it released.
  task automatic bus(logic w, logic [15:0] i, logic [3:0] v,
                     output logic [31:0] r);
    int t = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wdat <= {28'h0, v};
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b0 && t < 50);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    guard("bus wait", t, 50);
  endtask

  task automatic wreg(logic [15:0] i, logic [3:0] v);
    logic [31:0] r;
    bus(1'b1, i, v, r);
  endtask

  task automatic rchk(string s, logic [15:0] i, logic [3:0] e);
    logic [31:0] r;
    bus(1'b0, i, 4'h0, r);
    cmp(s, {28'h0, e}, r);
  endtask

  // Follows one digit from the code write to the end of the mute hold, or to the retrigger that cuts it short.
  task automatic measure(int len, bit cont, bit retrig);
    int n = 0;
    while (tone !== 2'h1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    guard("tone start", n, 5);
    cmp("mute in tone", 32'h0, {31'h0, mute_n});
    if (cont) begin
      repeat (3 * TL) @(negedge clk);
      cmp("held tone", 32'h1, {30'h0, tone});
      wreg(TN, 4'h0);
    end
    n = 0;
    while (tone === 2'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    guard("tone end", n, 300);
    if (cont) begin
      cmp("tone stop", 32'h1, {31'h0, n < 4});
    end else begin
      near("tone length", len, n);
    end
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      cmp("pause level", 32'h0, {30'h0, tone});
      @(negedge clk);
      n++;
    end
    guard("flag wait", n, 300);
    near("pause length", PC, n);
    if (retrig) begin
      watch = 1'b1;
      wreg(FL, 4'h1);
      wreg(CD, 4'h9);
      @(negedge clk);
      watch = 1'b0;
      cmp("mute gap", 32'h0, {31'h0, gap});
    end else begin
      n = 0;
      while (mute_n === 1'b0 && n < 300) begin
        @(negedge clk);
        n++;
      end
      guard("mute wait", n, 300);
      near("mute hold", MH, n);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    adr = 18'h0;
    rd = 1'b0;
    wr = 1'b0;
    be = 4'hF;
    wdat = 32'h0;
    watch = 1'b0;
    gap = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp("idle pins", 32'h4, {29'h0, mute_n, pulse_pin_n, irq});
    rchk("ctrl reset", CT, 4'h0);
    rchk("tone reset", TN, 4'h3);
    rchk("code reset", CD, 4'h0);
    rchk("hook reset", HK, 4'h0);
    rchk("mask reset", MK, 4'h0);
    rchk("flag reset", FL, 4'h0);
    rchk("unmapped", 16'hFF00, 4'h0);
    be <= 4'h0;
    wreg(HK, 4'hF);
    be <= 4'hF;
    rchk("lane off", HK, 4'h0);
    wreg(HK, 4'hF);
    rchk("hook", HK, 4'hB);
    @(negedge clk);
    cmp("off hook", 32'h1, {31'h0, hooked});
    wreg(CT, 4'h8);
    rchk("pulse mode", CT, 4'h8);
    wreg(CT, 4'hF);
    rchk("ctrl bits", CT, 4'hB);
    wreg(CD, 4'h5);
    repeat (30) @(negedge clk);
    cmp("pulse quiet", 32'h1, {29'h0, tone, mute_n});
    rchk("pulse flag", FL, 4'h0);
    wreg(CT, 4'h0);
    wreg(MK, 4'h1);
    // Oscillator settling time before the first digit.
    repeat (200) @(posedge clk);
    wreg(TN, 4'h0);
    wreg(CD, 4'h1);
    measure(TL, 1'b0, 1'b0);
    wreg(FL, 4'h1);
    wreg(TN, 4'h4);
    rchk("dur sel", TN, 4'h4);
    wreg(CD, 4'hE);
    measure(TS, 1'b0, 1'b0);
    wreg(FL, 4'h1);
    wreg(TN, 4'h8);
    wreg(CD, 4'h0);
    measure(0, 1'b1, 1'b0);
    wreg(MK, 4'h0);
    @(negedge clk);
    cmp("masked irq", 32'h0, {31'h0, irq});
    rchk("flag set", FL, 4'h1);
    wreg(MK, 4'h1);
    @(negedge clk);
    cmp("unmasked irq", 32'h1, {31'h0, irq});
    wreg(FL, 4'h0);
    rchk("flag kept", FL, 4'h1);
    wreg(FL, 4'h1);
    rchk("flag clear", FL, 4'h0);
    cmp("irq clear", 32'h0, {31'h0, irq});
    wreg(CD, 4'hA);
    measure(TL, 1'b0, 1'b1);
    measure(TL, 1'b0, 1'b0);
    wreg(FL, 4'h1);
    // Column tone alone, held on: one high half period of its divider.
    wreg(TN, 4'h9);
    wreg(CD, 4'h0);
    k = 0;
    while (tone !== 2'h2 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    guard("col rise", k, 40000);
    k = 0;
    while (tone === 2'h2 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    guard("col fall", k, 40000);
    near("col half", `DTD_COL4_HALF * OSC_RATIO, k);
    wreg(TN, 4'h0);
    k = 0;
    while (irq !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    guard("col flag", k, 300);
    wreg(FL, 4'h1);
    wreg(HK, 4'h3);
    @(negedge clk);
    cmp("on hook", 32'h0, {31'h0, hooked});
    report_and_stop();
  end
endmodule
`default_nettype wire
